// ---- rtl/asp_pkg.sv ----
/*
 Constants and types of the axis select and shutdown control block.
 Assumes a single 200 MHz clock and a byte-wide register port from the host interface logic.
*/
package asp_pkg;
  localparam logic [7:0] ASP_CTRL_ADDR  = 8'h19;
  localparam logic [7:0] ASP_CTRL_RESET = 8'h00;
  localparam logic [7:0] ASP_CTRL_MASK  = 8'h1F;
  localparam int         ASP_BIT_MAG    = 4;
  localparam int         ASP_BIT_XSKIP  = 3;
  localparam int         ASP_BIT_YSKIP  = 2;
  localparam int         ASP_BIT_ZSKIP  = 1;
  localparam int         ASP_BIT_SHDN   = 0;
  localparam logic [1:0] ASP_CD_MODE_MAG = 2'h1;

  typedef enum logic [1:0] {
    ASP_RUN      = 2'b00,
    ASP_SHUTDOWN = 2'b01,
    ASP_MOTION   = 2'b10
  } asp_state_type;
endpackage

// ---- rtl/asp_pin_sync.sv ----
/*
 Three-flop synchroniser with agreement filter for an asynchronous pin.
 Assumes the pin level may change at any time relative to clock.
*/
module asp_pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // Pin and filtered level
  input  wire logic pin,
  output logic      level
);
  logic [2:0] sync_reg;

  // Shift chain; stage 0 is only read by stage 1; reset to the pin's idle level
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sync_reg <= {3{RESET_LEVEL}};
    end else begin
      sync_reg <= {sync_reg[1:0], pin};
    end
  end

  // Change counts once stages one and two agree
  always_ff @(posedge clock) begin
    if (!rstn) begin
      level <= RESET_LEVEL;
    end else if (sync_reg[1] == sync_reg[2]) begin
      level <= sync_reg[2];
    end
  end
endmodule // asp_pin_sync

// ---- rtl/asp_ctrl.sv ----
/*
 Axis select and shutdown control register with deep shutdown sequencing.
 Assumes host interface logic presents byte writes/reads with an address and a one-cycle strobe;
 boot select is a static strap; wake and motion pins are asynchronous.
*/
module asp_ctrl (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Host register port
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Interrupt pin settings from elsewhere
  input  wire logic       soft_reset,
  input  wire logic       irq_driver_type_in,
  input  wire logic       irq_polarity_in,
  input  wire logic       irq_settings_wr,
  output logic            irq_driver_type,
  output logic            irq_polarity,
  // Pins
  input  wire logic       boot_select_pin,
  input  wire logic       wake_pin,
  input  wire logic       motion_detect_pin,
  // Data path control
  input  wire logic [1:0] cd_mode,
  input  wire logic       odr_tick,
  output logic            magnitude_calc_strobe,
  output logic            magnitude_in_burst,
  output logic            x_in_burst,
  output logic            y_in_burst,
  output logic            z_in_burst,
  output logic            cd_use_magnitude,
  // Power state
  output logic            power_follow_modes,
  output logic            deep_shutdown,
  output logic            volatile_clear,
  output logic            motion_boot
);
  logic [7:0]             ctrl_reg;
  logic                   boot_sel_reg;
  logic                   wake_lvl;
  logic                   motion_lvl;
  logic                   wake_ref_reg;
  asp_pkg::asp_state_type state_reg;
  asp_pkg::asp_state_type state_next;
  logic                   shdn_req;

  // Pin synchronisers; wake idles high, so no false edge after reset
  asp_pin_sync #(
    .RESET_LEVEL (1'b1)
  ) u_wake_sync (
    .clock (clock),
    .rstn  (rstn),
    .pin   (wake_pin),
    .level (wake_lvl)
  );
  asp_pin_sync u_mot_sync (
    .clock (clock),
    .rstn  (rstn),
    .pin   (motion_detect_pin),
    .level (motion_lvl)
  );

  // Strap is a pin too, so it passes the same filter
  asp_pin_sync u_boot_sync (
    .clock (clock),
    .rstn  (rstn),
    .pin   (boot_select_pin),
    .level (boot_sel_reg)
  );

  assign shdn_req = reg_wr && (reg_addr == asp_pkg::ASP_CTRL_ADDR) && reg_wdata[asp_pkg::ASP_BIT_SHDN];

  // Control register; shutdown wipes it
  always_ff @(posedge clock) begin
    if (!rstn || volatile_clear) begin
      ctrl_reg <= asp_pkg::ASP_CTRL_RESET;
    end else if (reg_wr && reg_addr == asp_pkg::ASP_CTRL_ADDR && state_reg == asp_pkg::ASP_RUN) begin
      ctrl_reg <= reg_wdata & asp_pkg::ASP_CTRL_MASK;
    end
  end

  // Read data register; unused bits zero
  always_ff @(posedge clock) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == asp_pkg::ASP_CTRL_ADDR) begin
      reg_rdata <= ctrl_reg & asp_pkg::ASP_CTRL_MASK;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Irq settings kept over soft reset, lost on shutdown
  always_ff @(posedge clock) begin
    if (!rstn || volatile_clear) begin
      irq_driver_type <= 1'b0;
      irq_polarity    <= 1'b1;
    end else if (irq_settings_wr && !soft_reset) begin
      irq_driver_type <= irq_driver_type_in;
      irq_polarity    <= irq_polarity_in;
    end
  end

  // Wake reference level latched at the shutdown request
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wake_ref_reg <= 1'b0;
    end else if (shdn_req && state_reg == asp_pkg::ASP_RUN) begin
      wake_ref_reg <= wake_lvl;
    end
  end

  // Power state selection
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      asp_pkg::ASP_RUN: begin
        if (boot_sel_reg) begin
          state_next = motion_lvl ? asp_pkg::ASP_MOTION : asp_pkg::ASP_SHUTDOWN;
        end else if (shdn_req) begin
          state_next = asp_pkg::ASP_SHUTDOWN;
        end
      end
      asp_pkg::ASP_SHUTDOWN: begin
        if (boot_sel_reg) begin
          if (motion_lvl) begin
            state_next = asp_pkg::ASP_MOTION;
          end
        end else if (wake_lvl != wake_ref_reg) begin
          state_next = asp_pkg::ASP_RUN;
        end
      end
      asp_pkg::ASP_MOTION: begin
        if (!boot_sel_reg) begin
          state_next = asp_pkg::ASP_RUN;
        end else if (!motion_lvl) begin
          state_next = asp_pkg::ASP_SHUTDOWN;
        end
      end
      default: begin
        state_next = asp_pkg::ASP_RUN;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg <= asp_pkg::ASP_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Power outputs from registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      volatile_clear <= 1'b0;
    end else begin
      volatile_clear <= (state_next == asp_pkg::ASP_SHUTDOWN) && (state_reg != asp_pkg::ASP_SHUTDOWN);
    end
  end

  assign deep_shutdown      = (state_reg == asp_pkg::ASP_SHUTDOWN);
  assign motion_boot        = (state_reg == asp_pkg::ASP_MOTION);
  assign power_follow_modes = (state_reg != asp_pkg::ASP_SHUTDOWN) && !ctrl_reg[asp_pkg::ASP_BIT_SHDN];

  // Data path steering from the register
  always_ff @(posedge clock) begin
    if (!rstn) begin
      magnitude_calc_strobe <= 1'b0;
      cd_use_magnitude      <= 1'b0;
    end else begin
      magnitude_calc_strobe <= odr_tick && ctrl_reg[asp_pkg::ASP_BIT_MAG] && !deep_shutdown;
      cd_use_magnitude      <= ctrl_reg[asp_pkg::ASP_BIT_MAG] && (cd_mode == asp_pkg::ASP_CD_MODE_MAG);
    end
  end

  assign magnitude_in_burst = ctrl_reg[asp_pkg::ASP_BIT_MAG];
  assign x_in_burst         = !ctrl_reg[asp_pkg::ASP_BIT_XSKIP];
  assign y_in_burst         = !ctrl_reg[asp_pkg::ASP_BIT_YSKIP];
  assign z_in_burst         = !ctrl_reg[asp_pkg::ASP_BIT_ZSKIP];

  // Assertions
  a_mag_strobe_gate: assert property (@(posedge clock) disable iff (!rstn)
    magnitude_calc_strobe |-> $past(ctrl_reg[asp_pkg::ASP_BIT_MAG]) && $past(odr_tick))
    else $error("magnitude computed while disabled");
  a_mag_strobe_fires: assert property (@(posedge clock) disable iff (!rstn)
    (odr_tick && ctrl_reg[asp_pkg::ASP_BIT_MAG] && !deep_shutdown) |=> magnitude_calc_strobe)
    else $error("magnitude not computed on output cycle");
  a_cd_mag_route: assert property (@(posedge clock) disable iff (!rstn)
    (ctrl_reg[asp_pkg::ASP_BIT_MAG] && cd_mode == asp_pkg::ASP_CD_MODE_MAG) |=> cd_use_magnitude)
    else $error("magnitude not routed to change detection");
  a_axis_skip_x: assert property (@(posedge clock) disable iff (!rstn)
    (reg_wr && reg_addr == asp_pkg::ASP_CTRL_ADDR && state_reg == asp_pkg::ASP_RUN && !boot_sel_reg
     && !shdn_req) |=> (x_in_burst == !$past(reg_wdata[asp_pkg::ASP_BIT_XSKIP])))
    else $error("x axis burst membership wrong");
  a_shdn_entry: assert property (@(posedge clock) disable iff (!rstn)
    (shdn_req && state_reg == asp_pkg::ASP_RUN && !boot_sel_reg) |=> deep_shutdown ##1 (ctrl_reg == 8'h00))
    else $error("shutdown request not honoured");
  a_wake_edge: assert property (@(posedge clock) disable iff (!rstn)
    (deep_shutdown && !boot_sel_reg && wake_lvl == wake_ref_reg) |=> (deep_shutdown || state_reg != asp_pkg::ASP_RUN)
    || $past(wake_lvl) != $past(wake_ref_reg))
    else $error("left shutdown without wake edge");
  a_motion_low: assert property (@(posedge clock) disable iff (!rstn)
    (boot_sel_reg && !motion_lvl && $past(boot_sel_reg)) |=> deep_shutdown)
    else $error("motion pin low did not shut down");
  a_reset_zero: assert property (@(posedge clock)
    !rstn |=> (ctrl_reg == 8'h00))
    else $error("register not zero after reset");
  a_upper_zero: assert property (@(posedge clock) disable iff (!rstn)
    reg_rdata[7:5] == 3'h0)
    else $error("unused bits read non-zero");
  a_motion_high: assert property (@(posedge clock) disable iff (!rstn)
    (boot_sel_reg && motion_lvl && $past(boot_sel_reg)) |=> motion_boot)
    else $error("motion pin high did not boot");
  a_follow_modes: assert property (@(posedge clock) disable iff (!rstn)
    $fell(deep_shutdown) |-> power_follow_modes)
    else $error("power mode not followed");
  a_irq_keep: assert property (@(posedge clock) disable iff (!rstn)
    (soft_reset && !volatile_clear) |=> $stable(irq_polarity))
    else $error("irq setting lost on soft reset");

  c_shutdown: cover property (@(posedge clock) disable iff (!rstn) $rose(deep_shutdown));
  c_wake: cover property (@(posedge clock) disable iff (!rstn) $fell(deep_shutdown) && !boot_sel_reg);
  c_motion: cover property (@(posedge clock) disable iff (!rstn) $rose(motion_boot));
  c_mag: cover property (@(posedge clock) disable iff (!rstn) magnitude_calc_strobe);
endmodule // asp_ctrl

// ---- bench/asp_host_model.sv ----
/*
 Host-side pin model: wake and motion pins plus the boot delay wait.
 Assumes the bench requests pin changes; pins move off the clock edge.
*/
module asp_host_model #(
  parameter int BOOT_DELAY = 20
) (
  // Clock
  input  wire logic clock,
  // Requests from the bench
  input  wire logic wake_req,
  input  wire logic motion_level,
  // Pins and readiness
  output logic      wake_pin,
  output logic      motion_detect_pin,
  output logic      host_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  int   wait_cnt   = 0;
  logic wake_last  = 1'b1;
  logic mot_last   = 1'b0;
  logic wake_state = 1'b1;
  logic mot_state  = 1'b0;
  // Wake toggles away from its held level, motion follows, off the edge
  always @(posedge wake_req) #3 wake_state = ~wake_state;
  always @(motion_level) #3 mot_state = motion_level;
  // Pins start idle: wake high, motion low
  assign wake_pin          = wake_state;
  assign motion_detect_pin = mot_state;
  // Restart the boot delay count on any pin change
  always @(posedge clock) begin
    wake_last <= wake_pin;
    mot_last <= motion_detect_pin;
    if (wake_pin !== wake_last || motion_detect_pin !== mot_last) wait_cnt <= 0;
    else if (wait_cnt < BOOT_DELAY) wait_cnt <= wait_cnt + 1;
  end
  assign host_ready = (wait_cnt >= BOOT_DELAY);
endmodule // asp_host_model

// ---- bench/tb_axis_select_and_shutdown_control.sv ----
/*
 Self-checking bench for the control register and shutdown sequencing.
 Assumes a 200 MHz clock and the host pin model beside the design.
*/
module tb_axis_select_and_shutdown_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock = 1'b0, rstn = 1'b0, reg_wr = 1'b0, soft_reset = 1'b0;
  logic       drv_in = 1'b0, pol_in = 1'b0, irq_wr = 1'b0, boot_sel = 1'b0;
  logic       odr_tick = 1'b0, wake_req = 1'b0, motion_level = 1'b0, s;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [1:0] cd_mode = 2'h0;
  logic       irq_drv, irq_pol, wake_pin, mot_pin, mag_strobe, mag_burst, x_b, y_b, z_b;
  logic       cd_mag, follow, shdn, vclr, mboot, host_ready;
  int         num_errors = 0;
  int         n_compared = 0;

  asp_ctrl dut_u (.clock(clock), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .soft_reset(soft_reset), .irq_driver_type_in(drv_in), .irq_polarity_in(pol_in),
    .irq_settings_wr(irq_wr), .irq_driver_type(irq_drv), .irq_polarity(irq_pol), .boot_select_pin(boot_sel),
    .wake_pin(wake_pin), .motion_detect_pin(mot_pin), .cd_mode(cd_mode), .odr_tick(odr_tick),
    .magnitude_calc_strobe(mag_strobe), .magnitude_in_burst(mag_burst), .x_in_burst(x_b), .y_in_burst(y_b),
    .z_in_burst(z_b), .cd_use_magnitude(cd_mag), .power_follow_modes(follow), .deep_shutdown(shdn),
    .volatile_clear(vclr), .motion_boot(mboot));
  asp_host_model host_u (.clock(clock), .wake_req(wake_req), .motion_level(motion_level),
    .wake_pin(wake_pin), .motion_detect_pin(mot_pin), .host_ready(host_ready));

  // Clock
  always #2.5 clock = ~clock;

  // Compare and count
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Register port accesses
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    reg_addr <= a;
    @(posedge clock);
    #1 chk(what, exp, reg_rdata);
  endtask
  // One output data cycle
  task automatic tick(input logic [1:0] m);
    @(posedge clock);
    odr_tick <= 1'b1;
    cd_mode <= m;
    @(posedge clock);
    odr_tick <= 1'b0;
    #1 s = mag_strobe;
  endtask
  // Bounded wait on shutdown (sel 0) or motion boot (sel 1)
  task automatic wait_sig(input bit sel, input logic lvl, input string what);
    int i;
    for (i = 0; i < 40 && (sel ? mboot : shdn) !== lvl; i++) @(posedge clock);
    #1 chk(what, {7'h00, lvl}, {7'h00, sel ? mboot : shdn});
  endtask
  task automatic wait_ready;
    int i;
    for (i = 0; i < 100 && host_ready !== 1'b1; i++) @(posedge clock);
    chk("host ready", 8'h01, {7'h00, host_ready});
  endtask
  // Verdict
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog
  initial begin
    #20000;
    num_errors++;
    finish_test;
  end

  // Test sequence
  initial begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    rd(8'h19, 8'h00, "ctrl reset");
    chk("axes", 8'h07, {5'h00, x_b, y_b, z_b});
    chk("follow", 8'h01, {7'h00, follow});
    $display("test reset done");
    wr(8'h19, 8'hFE);
    rd(8'h19, 8'h1E, "ctrl rw");
    chk("burst set", 8'h08, {4'h0, mag_burst, x_b, y_b, z_b});
    tick(2'h1);
    chk("strobe cd", 8'h03, {6'h00, s, cd_mag});
    tick(2'h2);
    chk("cd other", 8'h02, {6'h00, s, cd_mag});
    wr(8'h19, 8'h0A);
    #1 chk("axes mixed", 8'h02, {4'h0, mag_burst, x_b, y_b, z_b});
    wr(8'h19, 8'h00);
    tick(2'h1);
    chk("mag off", 8'h00, {5'h00, s, cd_mag, mag_burst});
    $display("test config done");
    @(posedge clock);
    irq_wr <= 1'b1;
    drv_in <= 1'b1;
    @(posedge clock);
    irq_wr <= 1'b0;
    @(posedge clock);
    irq_wr <= 1'b1;
    drv_in <= 1'b0;
    soft_reset <= 1'b1;
    @(posedge clock);
    irq_wr <= 1'b0;
    soft_reset <= 1'b0;
    #1 chk("irq kept", 8'h02, {6'h00, irq_drv, irq_pol});
    wr(8'h19, 8'h11);
    #1 chk("shdn entry", 8'h06, {5'h00, shdn, vclr, follow});
    wr(8'h19, 8'h10);
    rd(8'h19, 8'h00, "ctrl wiped");
    chk("irq wiped", 8'h01, {6'h00, irq_drv, irq_pol});
    @(posedge clock);
    wake_req <= 1'b1;
    wait_sig(1'b0, 1'b0, "wake exit");
    wait_ready;
    wr(8'h1A, 8'h1F);
    rd(8'h19, 8'h00, "other addr");
    $display("test shutdown done");
    @(posedge clock);
    boot_sel <= 1'b1;
    wait_sig(1'b0, 1'b1, "motion low");
    @(posedge clock);
    motion_level <= 1'b1;
    wait_sig(1'b1, 1'b1, "motion boot");
    chk("awake", 8'h00, {7'h00, shdn});
    wait_ready;
    @(posedge clock);
    motion_level <= 1'b0;
    wait_sig(1'b0, 1'b1, "motion drop");
    chk("boot off", 8'h00, {7'h00, mboot});
    $display("test motion done");
    finish_test;
  end
endmodule // tb_axis_select_and_shutdown_control
